// ===== rtl/sie_cfg_consts.vh
/*
 constants for the usb configuration, transfer-status and endpoint control block.
 assumes an apb slave at byte addresses below; included by bare name.
*/
// Summary of operation
// - config bit 3 set disables the on-chip transceiver; resets to 0.
// - config bit 2 selects full speed when 1, low speed when 0.
// - config bit 4 enables pull-up, only while module_enable is high and the transceiver is active.
// - enabled pull-up goes to D+ at full speed, D- at low speed.
// - config bits 1-0 select ping-pong usage; 00 disables it everywhere.
// - config bit 7 drives J-K repeating (K-J at full speed) while set and module_enable is high.
// - transfer status reads the head of a four-entry completion fifo.
// - transfer status is valid only while the completion flag is set.
// - clearing the flag pops the fifo; flag returns within 6 cycles if more.
// - host request while fifo is full is answered with NAK.
// - status bits 6-3 endpoint, 2 direction, 1 bank; bits 7 and 0 zero.
// - sixteen identical endpoint registers; bits 7-5 read 0; reset 0.
// - endpoint bit 4 enables handshakes; clear suppresses them.
// - endpoint bit 3 clear permits SETUP; set blocks control, keeps IN/OUT.
// - endpoint bit 2 enables OUT, bit 1 enables IN.
// - endpoint bit 0 stall set by engine on STALL, held until cleared.
// - stall bit acts only while the endpoint is enabled.
`ifndef SIE_CFG_CONSTS_VH
`define SIE_CFG_CONSTS_VH
// ****************************************
// register map
// ****************************************
`define A_CONFIG      12'h000
`define A_STATUS      12'h004
`define A_FLAG        12'h008
`define A_EP_BASE     12'h040
`define A_EP_LAST     12'h07C
// ****************************************
// fields
// ****************************************
`define CF_EYE        7
`define CF_PULLUP     4
`define CF_XCVR_DIS   3
`define CF_FULL_SPEED 2
`define CF_PP_HI      1
`define CF_PP_LO      0
`define CF_WMASK      8'h9F
`define EP_HSHK       4
`define EP_SETUP_DIS  3
`define EP_OUT_EN     2
`define EP_IN_EN      1
`define EP_STALL      0
`define EP_WMASK      5'h1F
`define PP_NONE       2'h0
`define PP_EP0_OUT    2'h1
`define PP_ALL        2'h2
`define PP_EP1_15     2'h3
`define PID_OUT       2'h0
`define PID_IN        2'h1
`define PID_SETUP     2'h2
`define HS_ACK        2'h0
`define HS_NAK        2'h1
`define HS_STALL      2'h2
`define HS_NONE       2'h3
`define REARM_NS      30
`endif

// ===== rtl/sie_cfg_ep_ctrl.v
/*
 configuration, transfer-status and endpoint control of a usb serial engine.
 assumes an apb master on pclk and a packet engine offering token and
 completion strobes synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sie_cfg_consts.vh"
module sie_cfg_ep_ctrl
#(
   parameter CLK_MHZ = 200,
   parameter NUM_EP  = 16,
   parameter FDEPTH  = 2
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        module_enable,
   input  wire        tok_valid,
   input  wire [3:0]  tok_ep,
   input  wire [1:0]  tok_pid,
   input  wire        stall_issued,
   input  wire [3:0]  stall_ep,
   input  wire        xfer_done,
   input  wire [3:0]  xfer_ep,
   input  wire        xfer_in,
   input  wire        xfer_bank,
   output reg         hs_valid,
   output reg  [1:0]  hs_code,
   output reg         tok_accept,
   output reg         xcvr_enable,
   output reg         full_speed,
   output reg         pullup_dp,
   output reg         pullup_dm,
   output reg  [15:0] pingpong_ep_out,
   output reg  [15:0] pingpong_ep_in,
   output reg         eye_active,
   output reg         eye_dp,
   output reg         eye_dm,
   output reg         transfer_complete_flag
);
   // rearm delay rounded up, never below two cycles
   localparam integer REARM_RAW = (`REARM_NS * CLK_MHZ + 999) / 1000;
   localparam integer REARM_MIN = (REARM_RAW < 2) ? 2 : REARM_RAW;
   localparam [7:0]   REARM_CYC = REARM_MIN[7:0];
   localparam [1:0] FS_IDLE = 2'h0;
   localparam [1:0] FS_WAIT = 2'h1;
   localparam [1:0] FS_FLAG = 2'h2;
   // ****************************************
   // registers
   // ****************************************
   reg  [7:0]  cfg_r;
   reg  [4:0]  ep_r [0:NUM_EP-1];
   reg  [1:0]  fstate_r;
   reg  [7:0]  wait_r;
   reg         eye_ph_r;
   reg         pop;
   reg  [4:0]  tok_cfg;
   reg         tok_allow;
   wire [5:0]  head;
   wire        ff_full;
   wire        ff_empty;
   wire        wr_acc;
   wire        rd_acc;
   wire        mapped;
   wire        is_ep;
   wire [3:0]  ep_idx;
   wire        xcvr_on;
   function ep_enabled;
      input [4:0] c;
      begin
         ep_enabled = c[`EP_OUT_EN] | c[`EP_IN_EN];
      end
   endfunction
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;
   assign is_ep  = (paddr >= `A_EP_BASE) && (paddr <= `A_EP_LAST) && (paddr[1:0] == 2'h0);
   assign ep_idx = paddr[5:2];
   assign mapped = is_ep || paddr == `A_CONFIG || paddr == `A_STATUS || paddr == `A_FLAG;
   assign xcvr_on = !cfg_r[`CF_XCVR_DIS];
   // ****************************************
   // apb slave, no wait states
   // ****************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= 32'h0;
         if (rd_acc)
         begin
            if (paddr == `A_CONFIG)
               prdata <= {24'h0, cfg_r & `CF_WMASK};
            else if (paddr == `A_STATUS && transfer_complete_flag)
               prdata <= {24'h0, 1'b0, head, 1'b0};
            else if (paddr == `A_FLAG)
               prdata <= {31'h0, transfer_complete_flag};
            else if (is_ep)
               prdata <= {27'h0, ep_r[ep_idx]};
         end
      end
   end
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_r <= 8'h00;
      else if (wr_acc && pready && paddr == `A_CONFIG)
         cfg_r <= pwdata[7:0] & `CF_WMASK;
   end
   // ****************************************
   // endpoint control registers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NUM_EP; g = g + 1)
      begin : ep_gen
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               ep_r[g] <= 5'h00;
            else
            begin
               if (wr_acc && pready && is_ep && ep_idx == g)
                  ep_r[g] <= pwdata[4:0] & `EP_WMASK;
               if (stall_issued && stall_ep == g)
                  ep_r[g][`EP_STALL] <= 1'b1;
            end
         end
      end
   endgenerate
   // ****************************************
   // token screening and handshake
   // ****************************************
   always @*
   begin
      tok_cfg = ep_r[tok_ep];
      case (tok_pid)
         `PID_OUT:   tok_allow = tok_cfg[`EP_OUT_EN];
         `PID_IN:    tok_allow = tok_cfg[`EP_IN_EN];
         `PID_SETUP: tok_allow = !tok_cfg[`EP_SETUP_DIS] && ep_enabled(tok_cfg);
         default:    tok_allow = 1'b0;
      endcase
   end
   // ****************************************
   // handshake registers
   // ****************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hs_valid   <= 1'b0;
         hs_code    <= `HS_NONE;
         tok_accept <= 1'b0;
      end
      else
      begin
         hs_valid   <= tok_valid && tok_allow && tok_cfg[`EP_HSHK];
         tok_accept <= tok_valid && tok_allow && !ff_full && !tok_cfg[`EP_STALL];
         if (ep_enabled(tok_cfg) && tok_cfg[`EP_STALL])
            hs_code <= `HS_STALL;
         else if (ff_full)
            hs_code <= `HS_NAK;
         else
            hs_code <= `HS_ACK;
      end
   end
   // ****************************************
   // status fifo and completion flag
   // ****************************************
   status_fifo #(.W(6), .AW(FDEPTH)) u_fifo
   (
      .clk   (pclk),
      .rst_n (presetn),
      .push  (xfer_done),
      .din   ({xfer_ep, xfer_in, xfer_bank}),
      .pop   (pop),
      .head_r(head),
      .full  (ff_full),
      .empty (ff_empty)
   );
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fstate_r               <= FS_IDLE;
         wait_r                 <= 8'h00;
         pop                    <= 1'b0;
         transfer_complete_flag <= 1'b0;
      end
      else
      begin
         pop <= 1'b0;
         case (fstate_r)
            FS_IDLE:
               if (!ff_empty)
               begin
                  fstate_r <= FS_WAIT;
                  wait_r   <= 8'h01;
               end
            FS_WAIT:
               if (wait_r == 8'h0)
               begin
                  fstate_r               <= FS_FLAG;
                  transfer_complete_flag <= 1'b1;
               end
               else
                  wait_r <= wait_r - 8'h01;
            FS_FLAG:
               if (wr_acc && pready && paddr == `A_FLAG && pwdata[0])
               begin
                  transfer_complete_flag <= 1'b0;
                  pop                    <= 1'b1;
                  fstate_r               <= FS_WAIT;
                  wait_r                 <= REARM_CYC - 8'h02;
               end
            default:
               fstate_r <= FS_IDLE;
         endcase
         if (fstate_r == FS_WAIT && wait_r == 8'h0 && ff_empty)
         begin
            fstate_r               <= FS_IDLE;
            transfer_complete_flag <= 1'b0;
         end
      end
   end
   // ****************************************
   // transceiver, pull-up, ping-pong, eye test
   // ****************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         xcvr_enable     <= 1'b0;
         full_speed      <= 1'b0;
         pullup_dp       <= 1'b0;
         pullup_dm       <= 1'b0;
         pingpong_ep_out <= 16'h0000;
         pingpong_ep_in  <= 16'h0000;
         eye_active      <= 1'b0;
         eye_dp          <= 1'b0;
         eye_dm          <= 1'b0;
         eye_ph_r        <= 1'b0;
      end
      else
      begin
         xcvr_enable <= xcvr_on;
         full_speed  <= cfg_r[`CF_FULL_SPEED];
         pullup_dp   <= module_enable && xcvr_on && cfg_r[`CF_PULLUP]
                        && cfg_r[`CF_FULL_SPEED];
         pullup_dm   <= module_enable && xcvr_on && cfg_r[`CF_PULLUP]
                        && !cfg_r[`CF_FULL_SPEED];
         case (cfg_r[`CF_PP_HI:`CF_PP_LO])
            `PP_NONE:
            begin
               pingpong_ep_out <= 16'h0000;
               pingpong_ep_in  <= 16'h0000;
            end
            `PP_EP0_OUT:
            begin
               pingpong_ep_out <= 16'h0001;
               pingpong_ep_in  <= 16'h0000;
            end
            `PP_ALL:
            begin
               pingpong_ep_out <= 16'hFFFF;
               pingpong_ep_in  <= 16'hFFFF;
            end
            default:
            begin
               pingpong_ep_out <= 16'hFFFE;
               pingpong_ep_in  <= 16'hFFFE;
            end
         endcase
         eye_active <= cfg_r[`CF_EYE] && module_enable;
         if (cfg_r[`CF_EYE] && module_enable)
         begin
            eye_ph_r <= !eye_ph_r;
            eye_dp   <= eye_ph_r ^ cfg_r[`CF_FULL_SPEED] ^ 1'b1;
            eye_dm   <= eye_ph_r ^ cfg_r[`CF_FULL_SPEED];
         end
         else
         begin
            eye_ph_r <= 1'b0;
            eye_dp   <= 1'b0;
            eye_dm   <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/status_fifo.v
/*
 four-entry completion status fifo with registered head output.
 assumes push is ignored when full and pop when empty.
*/
`timescale 1ns/1ps
`default_nettype none
module status_fifo
#(
   parameter W  = 6,
   parameter AW = 2
)
(
   input  wire          clk,
   input  wire          rst_n,
   input  wire          push,
   input  wire [W-1:0]  din,
   input  wire          pop,
   output reg  [W-1:0]  head_r,
   output wire          full,
   output wire          empty
);
   reg [W-1:0]  mem [0:(1<<AW)-1];
   reg [AW:0]   wp_r;
   reg [AW:0]   rp_r;
   wire         do_push;
   wire         do_pop;
   wire [AW:0]  rp_nxt;
   assign full    = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign empty   = (wp_r == rp_r);
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;
   assign rp_nxt  = do_pop ? rp_r + 1'b1 : rp_r;
   always @(posedge clk)
   begin
      if (do_push)
         mem[wp_r[AW-1:0]] <= din;
   end
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_r   <= {(AW+1){1'b0}};
         rp_r   <= {(AW+1){1'b0}};
         head_r <= {W{1'b0}};
      end
      else
      begin
         if (do_push)
            wp_r <= wp_r + 1'b1;
         rp_r <= rp_nxt;
         if (do_push && (wp_r[AW-1:0] == rp_nxt[AW-1:0]))
            head_r <= din;
         else
            head_r <= mem[rp_nxt[AW-1:0]];
      end
   end
endmodule
`default_nettype wire

// ===== testbench/sie_cfg_ep_ctrl_properties.sv
/*
 port checker for the usb config, status and endpoint block.
 assumes binding to sie_cfg_ep_ctrl, one clock, async low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sie_cfg_consts.vh"
module sie_cfg_props
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        tok_valid,
   input wire logic        hs_valid,
   input wire logic [1:0]  hs_code,
   input wire logic        tok_accept,
   input wire logic        transfer_complete_flag,
   input wire logic        xcvr_enable,
   input wire logic        full_speed,
   input wire logic        pullup_dp,
   input wire logic        pullup_dm,
   input wire logic        eye_active,
   input wire logic        eye_dp,
   input wire logic        eye_dm
);
   // ****************
   // properties
   // ****************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence
   sequence flag_clear_s;
      psel && penable && pready && pwrite && paddr == `A_FLAG && pwdata[0]
         && transfer_complete_flag;
   endsequence
   flag_clear_a: assert property (flag_clear_s |=> !transfer_complete_flag)
      else $error("flag not cleared by write");
   accept_ack_a: assert property (tok_accept |-> hs_code == `HS_ACK)
      else $error("accepted token without ack code");
   apb_answer_a: assert property (setup_s |=> answer_s)
      else $error("no one-cycle answer");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   hs_cause_a: assert property (hs_valid |-> $past(tok_valid))
      else $error("handshake without token");
   accept_cause_a: assert property (tok_accept |-> $past(tok_valid))
      else $error("accept without token");
   pullup_dp_a: assert property (pullup_dp |-> xcvr_enable && full_speed && !pullup_dm)
      else $error("bad pull-up on dp");
   pullup_dm_a: assert property (pullup_dm |-> xcvr_enable && !full_speed)
      else $error("bad pull-up on dm");
   eye_diff_a: assert property (eye_active |-> eye_dp != eye_dm)
      else $error("eye lines not differential");
   eye_toggle_a: assert property (eye_active && $past(eye_active) |-> eye_dp != $past(eye_dp))
      else $error("eye pattern not toggling");
endmodule
bind sie_cfg_ep_ctrl sie_cfg_props i_props
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .tok_valid, .hs_valid, .hs_code, .tok_accept, .transfer_complete_flag, .xcvr_enable,
   .full_speed, .pullup_dp, .pullup_dm, .eye_active, .eye_dp, .eye_dm
);
`default_nettype wire

// ===== testbench/test_usb_sie_config_status_endpoint_ctrl.sv
/*
 self-checking bench for the usb config, status and endpoint block.
 assumes the design header constants and the host model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sie_cfg_consts.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_usb_sie_config_status_endpoint_ctrl;
   // ****************
   // signals, apb master, scoreboard
   // ****************
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, module_enable;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed = 32'h9A18;
   logic tok_valid, stall_issued, xfer_done, xfer_in, xfer_bank, hs_valid, tok_accept;
   logic [3:0] tok_ep, stall_ep, xfer_ep;
   logic [1:0] tok_pid, hs_code;
   logic xcvr_enable, full_speed, pullup_dp, pullup_dm, eye_active, eye_dp, eye_dm;
   logic transfer_complete_flag;
   logic [15:0] pingpong_ep_out, pingpong_ep_in;
   logic [32:0] rq[$];
   int fails = 0, checks = 0;
   sie_cfg_ep_ctrl i_dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .module_enable(module_enable), .tok_valid(tok_valid), .tok_ep(tok_ep),
      .tok_pid(tok_pid), .stall_issued(stall_issued), .stall_ep(stall_ep),
      .xfer_done(xfer_done), .xfer_ep(xfer_ep), .xfer_in(xfer_in), .xfer_bank(xfer_bank),
      .hs_valid(hs_valid), .hs_code(hs_code), .tok_accept(tok_accept),
      .xcvr_enable(xcvr_enable), .full_speed(full_speed), .pullup_dp(pullup_dp),
      .pullup_dm(pullup_dm), .pingpong_ep_out(pingpong_ep_out),
      .pingpong_ep_in(pingpong_ep_in), .eye_active(eye_active), .eye_dp(eye_dp),
      .eye_dm(eye_dm), .transfer_complete_flag(transfer_complete_flag)
   );
   usb_host_model i_host
   (
      .pclk(pclk), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_pid(tok_pid),
      .stall_issued(stall_issued), .stall_ep(stall_ep), .xfer_done(xfer_done),
      .xfer_ep(xfer_ep), .xfer_in(xfer_in), .xfer_bank(xfer_bank)
   );
   initial
   begin
      pclk = 0;
      forever #2.5 pclk = ~pclk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task tally_and_finish;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, paddr, pwrite, pwdata} <= {2'h2, a, w, d};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (!pready && n < 20);
      {psel, penable} <= 2'h0;
      if (!pready)
      begin
         fails++;
         tally_and_finish();
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'h1, d);
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(a, 1'h0, 32'h0);
   endtask
   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task wflag(input int n);
      int k;
      for (k = 0; k < n && !transfer_complete_flag; k++)
         @(negedge pclk);
      if (!transfer_complete_flag)
      begin
         fails++;
         tally_and_finish();
      end
   endtask
   task tok(input logic [3:0] e, input logic [1:0] p, input logic acc, input logic hv,
            input logic [1:0] c);
      i_host.token(e, p);
      @(negedge pclk);
      `CHK(tok_accept, acc)
      `CHK(hs_valid, hv)
      if (hv)
         `CHK(hs_code, c)
   endtask
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite)
         `CHK({pslverr, prdata}, rq.pop_front())
   initial
   begin
      int i;
      logic [31:0] v;
      logic x;
      {presetn, psel, penable, pwrite, module_enable, paddr, pwdata} = 49'h0;
      tick(8);
      presetn <= 1'h1;
      rd(`A_CONFIG, 33'h0);
      rd(12'hFF0, 33'h1_0000_0000);
      for (i = 0; i < 32; i++)
      begin
         module_enable <= 1'h0;
         wr(`A_CONFIG, (rnd() & 32'hFFFFFF00) | i);
         module_enable <= 1'h1;
         rd(`A_CONFIG, i);
         tick(2);
         `CHK(xcvr_enable, !i[3])
         `CHK(full_speed, i[2])
         `CHK(pullup_dp, i[4] & !i[3] & i[2])
         `CHK(pullup_dm, i[4] & !i[3] & !i[2])
         v = i[1:0] == 1 ? 32'h1 : i[1:0] == 2 ? 32'hFFFF : i[1:0] == 3 ? 32'hFFFE : 32'h0;
         `CHK(pingpong_ep_out, v[15:0])
         `CHK(pingpong_ep_in, i[1:0] == 1 ? 16'h0 : v[15:0])
      end
      for (i = 0; i < 2; i++)
      begin
         module_enable <= 1'h0;
         wr(`A_CONFIG, 32'h90 | i << 2);
         module_enable <= 1'h1;
         tick(3);
         `CHK(eye_active, 1'h1)
         `CHK(eye_dm, ~eye_dp)
         x = eye_dp;
         tick(1);
         `CHK(eye_dp, ~x)
      end
      module_enable <= 1'h0;
      tick(2);
      `CHK(eye_active, 1'h0)
      `CHK(pullup_dp, 1'h0)
      wr(`A_CONFIG, 32'h14);
      module_enable <= 1'h1;
      tick(2);
      `CHK(eye_active, 1'h0)
      `CHK(pullup_dp, 1'h1)
      for (i = 0; i < 16; i++)
      begin
         v = rnd() & (i == 0 ? 32'hFFFFFFF7 : 32'hFFFFFFFF);
         wr(`A_EP_BASE + 4 * i, v);
         rd(`A_EP_BASE + 4 * i, {28'h0, v[4:0]});
      end
      wr(`A_EP_BASE + 12, 32'h16);
      wr(`A_EP_BASE + 20, 32'h0E);
      wr(`A_EP_BASE + 24, 32'h12);
      tok(3, `PID_OUT, 1, 1, `HS_ACK);
      tok(3, `PID_SETUP, 1, 1, `HS_ACK);
      tok(5, `PID_SETUP, 0, 0, 0);
      tok(5, `PID_IN, 1, 0, 0);
      tok(6, `PID_OUT, 0, 0, 0);
      i_host.stall(3);
      rd(`A_EP_BASE + 12, 33'h17);
      tok(3, `PID_IN, 0, 1, `HS_STALL);
      wr(`A_EP_BASE + 12, 32'h16);
      tok(3, `PID_IN, 1, 1, `HS_ACK);
      for (i = 0; i < 5; i++)
         i_host.done(i + 1, i[0], i[1]);
      tok(3, `PID_OUT, 0, 1, `HS_NAK);
      wflag(10);
      rd(`A_FLAG, 33'h1);
      for (i = 0; i < 4; i++)
      begin
         rd(`A_STATUS, {(i + 1) << 3 | i[0] << 2 | i[1] << 1});
         wr(`A_FLAG, 32'h1);
         tick(1);
         if (i < 3)
            wflag(6);
      end
      tick(8);
      `CHK(transfer_complete_flag, 1'h0)
      rd(`A_STATUS, 33'h0);
      tick(2);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ===== testbench/usb_host_model.sv
/*
 behavioural host and packet side: tokens, stalls, completions.
 assumes the bench calls its tasks one at a time, on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
(
   input  wire logic       pclk,
   output var  logic       tok_valid,
   output var  logic [3:0] tok_ep,
   output var  logic [1:0] tok_pid,
   output var  logic       stall_issued,
   output var  logic [3:0] stall_ep,
   output var  logic       xfer_done,
   output var  logic [3:0] xfer_ep,
   output var  logic       xfer_in,
   output var  logic       xfer_bank
);
   // ****************
   // one-cycle pulses, idle fields inverted
   // ****************
   initial
   begin
      {tok_valid, tok_ep, tok_pid, stall_issued, stall_ep} = 12'h0;
      {xfer_done, xfer_ep, xfer_in, xfer_bank} = 7'h0;
   end
   task token(input logic [3:0] e, input logic [1:0] p);
      @(posedge pclk);
      {tok_valid, tok_ep, tok_pid} <= {1'h1, e, p};
      @(posedge pclk);
      {tok_valid, tok_ep, tok_pid} <= {1'h0, ~e, ~p};
   endtask
   task stall(input logic [3:0] e);
      @(posedge pclk);
      {stall_issued, stall_ep} <= {1'h1, e};
      @(posedge pclk);
      {stall_issued, stall_ep} <= {1'h0, ~e};
   endtask
   task done(input logic [3:0] e, input logic i, input logic b);
      @(posedge pclk);
      {xfer_done, xfer_ep, xfer_in, xfer_bank} <= {1'h1, e, i, b};
      @(posedge pclk);
      {xfer_done, xfer_ep, xfer_in, xfer_bank} <= {1'h0, ~e, ~i, ~b};
   endtask
endmodule
`default_nettype wire
